// ==== hdl/eei_pkg.sv ====
// Shared constants and types for the encoder emulation and index block.
package eei_pkg;

   // ==========================================================
   // Parameter offsets
   localparam logic [7:0] ABS_INDEX_OFFSET = 8'hf8;
   localparam logic [7:0] RESOLUTION_OFFSET = 8'hfa;
   localparam logic [7:0] REV_INDEX_OFFSET = 8'hfc;

   // ==========================================================
   // Widths and values after reset
   localparam int RES_W = 24;
   localparam int ZOFF_W = 16;
   localparam int CPR_W = 26;
   localparam logic [31:0] ABS_INDEX_RESET = 32'h0000_0000;
   localparam logic [RES_W-1:0] RESOLUTION_RESET = 24'h00_0000;
   localparam logic [ZOFF_W-1:0] REV_INDEX_RESET = 16'h0000;

   // ==========================================================
   // Port modes
   typedef enum logic [2:0] {
      MODE_IN_NONE   = 3'b000,
      MODE_OUT_REV   = 3'b001,
      MODE_OUT_ABS   = 3'b010,
      MODE_IN_AB     = 3'b011,
      MODE_IN_STEP   = 3'b100,
      MODE_IN_UPDOWN = 3'b101
   } eei_mode_t;

endpackage

// ==== hdl/eei_step_if.sv ====
// Step events passed from the pin decoder to the counting core.
`timescale 1ns/1ns
interface eei_step_if;
   logic [2:0] mode;
   logic       up;
   logic       dn;
   modport dec (input mode, output up, output dn);
   modport core (output mode, input up, input dn);
endinterface

// ==== hdl/eei_pin_decode.sv ====
// Decoder that turns received encoder pin levels into count steps.
`timescale 1ns/1ns
module eei_pin_decode (
   // Clock and reset
   input wire logic mclk,
   input wire logic srst,
   // Received pin levels
   input wire logic a_in,
   input wire logic b_in,
   // Count steps
   eei_step_if.dec  stp
);

   logic a_reg;
   logic b_reg;

   // ==========================================================
   // Previous levels
   always_ff @(posedge mclk) begin
      if (srst) begin
         a_reg <= 1'b0;
         b_reg <= 1'b0;
      end else begin
         a_reg <= a_in;
         b_reg <= b_in;
      end
   end

   // ==========================================================
   // Step decode per mode
   always_comb begin
      stp.up = 1'b0;
      stp.dn = 1'b0;
      case (stp.mode)
         eei_pkg::MODE_IN_AB: begin
            // An edge on one channel alone is one count, direction from the phase; edges on both at once give none.
            if ((a_in ^ a_reg) && !(b_in ^ b_reg)) begin
               stp.up = a_in ^ b_in;
               stp.dn = ~(a_in ^ b_in);
            end else if ((b_in ^ b_reg) && !(a_in ^ a_reg)) begin
               stp.up = ~(a_in ^ b_in);
               stp.dn = a_in ^ b_in;
            end
         end
         eei_pkg::MODE_IN_STEP: begin
            stp.up = a_in && !a_reg && !b_in;
            stp.dn = a_in && !a_reg && b_in;
         end
         eei_pkg::MODE_IN_UPDOWN: begin
            // A rising edge on both lines at once cancels out.
            stp.up = a_in && !a_reg && !(b_in && !b_reg);
            stp.dn = b_in && !b_reg && !(a_in && !a_reg);
         end
         default: begin
            stp.up = 1'b0;
            stp.dn = 1'b0;
         end
      endcase
   end

endmodule

// ==== hdl/eei_encoder_emulation.sv ====
// Emulated encoder port: output emulation with index, and handwheel input counting.
//
// What this block does
// - In mode two, index pulses when feedback count equals absolute index position.
// - Absolute index position is an unsigned 32-bit count, reset to zero.
// - Resolution means lines per rev in modes one to three, counts in four, five.
// - Resolution accepts zero to 16,777,215 and resets to zero.
// - As output, exactly the programmed lines are produced per feedback revolution.
// - As input, the programmed received lines in mode three, or counts in modes four and five, make one handwheel revolution.
// - In mode one, index pulses when feedback angle within a rev equals the offset.
// - Index offset is in 1/65536 rev, zero to 65535, reset to zero.
// - Mode field selects input none, output rev, output abs, A/B, step, up-down.
// - Output direction is motor direction select xor emulation direction select.
`timescale 1ns/1ns
module eei_encoder_emulation (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        srst,
   // Parameter access
   input  wire logic [7:0]  par_addr,
   input  wire logic        par_wr,
   input  wire logic        par_rd,
   input  wire logic [31:0] par_wdata,
   output logic      [31:0] par_rdata,
   output logic             par_ack,
   // Configuration
   input  wire logic [2:0]  emulation_port_mode,
   input  wire logic        motor_direction_select,
   input  wire logic        emulation_direction_select,
   // Primary feedback
   input  wire logic [31:0] fb_turns,
   input  wire logic [15:0] fb_angle,
   // Emulated encoder port pins
   input  wire logic        a_in,
   output logic             a_out,
   output logic             a_oe,
   input  wire logic        b_in,
   output logic             b_out,
   output logic             b_oe,
   output logic             z_out,
   output logic             z_oe,
   // Handwheel position
   output logic      [31:0] handwheel_turns,
   output logic      [31:0] handwheel_count
);

   localparam int CW = eei_pkg::CPR_W;

   // ==========================================================
   // Helpers
   function automatic logic [CW-1:0] scale_rev(input logic [15:0] frac,
                                               input logic [CW-1:0] cpr);
      logic [CW+15:0] prod;
      prod = frac * cpr;
      return prod[CW+15:16];
   endfunction

   function automatic logic [31:0] wrap_step(input logic [31:0] cnt,
                                             input logic [CW-1:0] cpr,
                                             input logic up);
      logic [31:0] top;
      top = {6'h00, cpr} - 32'h0000_0001;
      if (cpr == '0) begin
         return 32'h0000_0000;
      end else if (up) begin
         return (cnt >= top) ? 32'h0000_0000 : cnt + 32'h0000_0001;
      end else begin
         return (cnt == 32'h0000_0000 || cnt > top) ? top : cnt - 32'h0000_0001;
      end
   endfunction

   // ==========================================================
   // Declarations
   logic [31:0]              abs_index_reg;
   logic [eei_pkg::RES_W-1:0]  resolution_reg;
   logic [eei_pkg::ZOFF_W-1:0] rev_index_reg;
   logic [31:0]              emu_cnt_reg;
   logic [31:0]              emu_cnt_next;
   logic [31:0]              rev_cnt_reg;
   logic [31:0]              rev_cnt_next;
   logic [CW-1:0]            out_cpr;
   logic [CW-1:0]            in_cpr;
   logic [CW-1:0]            zoff_cnt;
   logic [CW+31:0]           turn_prod;
   logic [31:0]              target_raw;
   logic [31:0]              target;
   logic [31:0]              diff;
   logic                     step_up;
   logic                     step_dn;
   logic                     out_mode;
   logic                     a_reg;
   logic                     b_reg;
   logic                     z_reg;
   eei_step_if               stp ();

   // ==========================================================
   // Parameter access
   always_ff @(posedge mclk) begin
      if (srst) begin
         abs_index_reg  <= eei_pkg::ABS_INDEX_RESET;
         resolution_reg <= eei_pkg::RESOLUTION_RESET;
         rev_index_reg  <= eei_pkg::REV_INDEX_RESET;
      end else if (par_wr) begin
         case (par_addr)
            eei_pkg::ABS_INDEX_OFFSET: abs_index_reg <= par_wdata;
            // Bits above the resolution range are dropped on write.
            eei_pkg::RESOLUTION_OFFSET: resolution_reg <= par_wdata[eei_pkg::RES_W-1:0];
            eei_pkg::REV_INDEX_OFFSET: rev_index_reg <= par_wdata[eei_pkg::ZOFF_W-1:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         par_rdata <= 32'h0000_0000;
         par_ack   <= 1'b0;
      end else begin
         par_ack <= par_rd || par_wr;
         if (par_rd) begin
            case (par_addr)
               eei_pkg::ABS_INDEX_OFFSET: par_rdata <= abs_index_reg;
               eei_pkg::RESOLUTION_OFFSET: par_rdata <= {8'h00, resolution_reg};
               eei_pkg::REV_INDEX_OFFSET: par_rdata <= {16'h0000, rev_index_reg};
               default: par_rdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ==========================================================
   // Output emulation
   assign out_mode = emulation_port_mode == eei_pkg::MODE_OUT_REV ||
                     emulation_port_mode == eei_pkg::MODE_OUT_ABS;
   // Four quadrature counts per line; lines per rev in output modes.
   assign out_cpr = {resolution_reg, 2'b00};
   assign zoff_cnt = scale_rev(rev_index_reg, out_cpr);
   assign turn_prod = fb_turns * out_cpr;
   // Whole turns plus the scaled angle, so every rev maps onto exactly out_cpr counts.
   assign target_raw = turn_prod[31:0] + {6'h00, scale_rev(fb_angle, out_cpr)};
   assign target = (motor_direction_select ^ emulation_direction_select) ?
                   32'h0000_0000 - target_raw : target_raw;
   assign diff = target - emu_cnt_reg;
   // One count per clock at most keeps A/B a clean gray sequence; fast moves lag briefly.
   assign step_up = out_mode && diff != 32'h0000_0000 && !diff[31];
   assign step_dn = out_mode && diff[31];

   always_comb begin
      emu_cnt_next = emu_cnt_reg;
      rev_cnt_next = rev_cnt_reg;
      if (step_up || step_dn) begin
         emu_cnt_next = step_up ? emu_cnt_reg + 32'h0000_0001 : emu_cnt_reg - 32'h0000_0001;
         rev_cnt_next = wrap_step(rev_cnt_reg, out_cpr, step_up);
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         emu_cnt_reg <= 32'h0000_0000;
         rev_cnt_reg <= 32'h0000_0000;
      end else begin
         emu_cnt_reg <= emu_cnt_next;
         rev_cnt_reg <= rev_cnt_next;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         a_reg <= 1'b0;
         b_reg <= 1'b0;
         z_reg <= 1'b0;
      end else begin
         a_reg <= emu_cnt_next[1];
         b_reg <= emu_cnt_next[1] ^ emu_cnt_next[0];
         // Index follows the count, so it lasts one count and moves with an A/B edge.
         case (emulation_port_mode)
            eei_pkg::MODE_OUT_REV:
               z_reg <= out_cpr != '0 && rev_cnt_next == {6'h00, zoff_cnt};
            eei_pkg::MODE_OUT_ABS:
               z_reg <= out_cpr != '0 && emu_cnt_next == abs_index_reg;
            default: z_reg <= 1'b0;
         endcase
      end
   end

   assign a_out = a_reg;
   assign b_out = b_reg;
   assign z_out = z_reg;
   assign a_oe = out_mode;
   assign b_oe = out_mode;
   assign z_oe = out_mode;

   // ==========================================================
   // Handwheel input
   assign stp.mode = out_mode ? eei_pkg::MODE_IN_NONE : emulation_port_mode;
   // Lines per rev for A/B input, counts per rev for step and up-down input.
   assign in_cpr = (emulation_port_mode == eei_pkg::MODE_IN_AB) ?
                   {resolution_reg, 2'b00} : {2'b00, resolution_reg};

   eei_pin_decode u_decode (
      .mclk (mclk),
      .srst (srst),
      .a_in (a_in),
      .b_in (b_in),
      .stp  (stp)
   );

   always_ff @(posedge mclk) begin
      if (srst) begin
         handwheel_count <= 32'h0000_0000;
         handwheel_turns <= 32'h0000_0000;
      end else if (stp.up || stp.dn) begin
         handwheel_count <= wrap_step(handwheel_count, in_cpr, stp.up);
         if (in_cpr != '0 && stp.up && handwheel_count >= {6'h00, in_cpr} - 32'h0000_0001) begin
            handwheel_turns <= handwheel_turns + 32'h0000_0001;
         end else if (in_cpr != '0 && stp.dn && handwheel_count == 32'h0000_0000) begin
            handwheel_turns <= handwheel_turns - 32'h0000_0001;
         end
      end
   end

endmodule

// ==== verification/eei_monitor.sv ====
// Port checker for the encoder emulation and index block.
`timescale 1ns/1ns
module eei_monitor (
   // Clock and reset
   input wire logic        mclk,
   input wire logic        srst,
   // Watched ports
   input wire logic [7:0]  par_addr,
   input wire logic        par_wr,
   input wire logic        par_rd,
   input wire logic [31:0] par_rdata,
   input wire logic        par_ack,
   input wire logic [2:0]  emulation_port_mode,
   input wire logic        a_out,
   input wire logic        a_oe,
   input wire logic        b_out,
   input wire logic        z_out
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);
   // ==========================================================
   // Sequences
   logic out_m;
   assign out_m = emulation_port_mode inside {3'h1, 3'h2};
   sequence quiet_s;
      !out_m [*2];
   endsequence
   sequence rd_s(logic [7:0] ad);
      par_rd && par_addr == ad;
   endsequence
   // ==========================================================
   // Assertions
   a_ack_follows: assert property ((par_wr || par_rd) |=> par_ack)
      else $error("ack missing after access");
   a_ack_only: assert property (!(par_wr || par_rd) |=> !par_ack)
      else $error("ack without access");
   a_rdata_hold: assert property (!par_rd |=> $stable(par_rdata))
      else $error("read data moved without read");
   a_res_mask: assert property (rd_s(eei_pkg::RESOLUTION_OFFSET)
      |=> par_rdata[31:24] == 8'h00)
      else $error("resolution upper bits set");
   a_off_mask: assert property (rd_s(eei_pkg::REV_INDEX_OFFSET)
      |=> par_rdata[31:16] == 16'h0000)
      else $error("offset upper bits set");
   a_oe_modes: assert property (a_oe == out_m)
      else $error("output enable wrong for mode");
   a_z_quiet: assert property (quiet_s |-> !z_out)
      else $error("index outside output modes");
   a_ab_quiet: assert property (quiet_s |-> $stable(a_out) && $stable(b_out))
      else $error("lines moved outside output modes");
   a_gray_step: assert property (!($changed(a_out) && $changed(b_out)))
      else $error("both channels changed at once");
endmodule

// ==== verification/eei_far_end.sv ====
// Far-end model: follower receiver and handwheel source.
`timescale 1ns/1ns
module eei_far_end (
   // Clock and reset
   input wire logic mclk,
   input wire logic srst,
   // Port pins
   input wire logic a_out,
   input wire logic a_oe,
   input wire logic b_out,
   input wire logic b_oe,
   output logic     a_line,
   output logic     b_line
);
   logic       a_drv = 1'b0;
   logic       b_drv = 1'b0;
   // The A/B phase persists across calls, so a later walk starts where the lines stand.
   logic [1:0] g = 2'h0;
   int         pos;
   logic [1:0] prev;
   logic [1:0] cur;
   // The block wins the shared lines while it drives them.
   assign a_line = a_oe ? a_out : a_drv;
   assign b_line = b_oe ? b_out : b_drv;
   assign cur = {a_line, a_line ^ b_line};
   always @(posedge mclk) begin
      if (srst) pos <= 0;
      else if (cur - prev == 2'h1) pos <= pos + 1;
      else if (prev - cur == 2'h1) pos <= pos - 1;
      prev <= cur;
   end
   // Quadrature counts in mode three, otherwise a pulse on A, or on B for down in mode five.
   task automatic send(input logic [2:0] m, input int n, input logic dn);
      repeat (n) begin
         if (m == 3'h3) g = dn ? g - 2'h1 : g + 2'h1;
         @(posedge mclk) #1;
         a_drv = (m == 3'h3) ? g[1] : !(m == 3'h5 && dn);
         b_drv = (m == 3'h3) ? g[1] ^ g[0] : dn;
         repeat (2) @(posedge mclk);
         #1 a_drv = (m == 3'h3) ? g[1] : 1'b0;
         b_drv = (m == 3'h3) ? g[1] ^ g[0] : 1'b0;
         repeat (2) @(posedge mclk);
      end
   endtask
endmodule

// ==== verification/eei_encoder_emulation_bench.sv ====
// Self-checking bench for the encoder emulation and index block.
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin num_errors++; \
   $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module eei_encoder_emulation_bench;
   logic        mclk = 1'b0;
   logic        srst = 1'b1;
   logic [7:0]  par_addr = 8'h00;
   logic        par_wr = 1'b0;
   logic        par_rd = 1'b0;
   logic [31:0] par_wdata = 32'h0;
   logic [2:0]  emulation_port_mode = 3'h0;
   logic        motor_direction_select = 1'b0;
   logic        emulation_direction_select = 1'b0;
   logic [31:0] fb_turns = 32'h0;
   logic [15:0] fb_angle = 16'h0;
   logic [31:0] par_rdata, handwheel_turns, handwheel_count, rv;
   logic        par_ack, a_in, a_out, a_oe, b_in, b_out, b_oe, z_out, z_oe;
   logic [2:0]  hw_mode [3] = '{3'h4, 3'h5, 3'h3};
   int          num_errors = 0;
   int          n_tests = 0;
   localparam logic [7:0] ABS = eei_pkg::ABS_INDEX_OFFSET;
   localparam logic [7:0] RES = eei_pkg::RESOLUTION_OFFSET;
   localparam logic [7:0] ZOF = eei_pkg::REV_INDEX_OFFSET;
   initial forever #50 mclk = ~mclk;
   eei_encoder_emulation dut_u (.mclk, .srst, .par_addr, .par_wr, .par_rd, .par_wdata,
      .par_rdata, .par_ack, .emulation_port_mode, .motor_direction_select,
      .emulation_direction_select, .fb_turns, .fb_angle, .a_in, .a_out, .a_oe, .b_in,
      .b_out, .b_oe, .z_out, .z_oe, .handwheel_turns, .handwheel_count);
   eei_far_end far_u (.mclk, .srst, .a_out, .a_oe, .b_out, .b_oe, .a_line(a_in),
      .b_line(b_in));
   // ==========================================================
   // Tasks
   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic acc(input logic w, input logic [7:0] ad, input logic [31:0] d);
      @(posedge mclk) #1;
      par_addr = ad;
      par_wdata = d;
      par_wr = w;
      par_rd = !w;
      cyc(1);
      par_wr = 1'b0;
      par_rd = 1'b0;
      `CHK("ack", 1'b1, par_ack)
      rv = par_rdata;
   endtask
   task automatic rdc(input string nm, input logic [7:0] ad, input logic [31:0] e);
      acc(1'b0, ad, 32'h0);
      `CHK(nm, e, rv)
   endtask
   task automatic do_reset();
      @(posedge mclk) #1;
      srst = 1'b1;
      cyc(10);
      srst = 1'b0;
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      do_reset();
      rdc("abs", ABS, eei_pkg::ABS_INDEX_RESET);
      rdc("res", RES, 32'h0);
      rdc("zoff", ZOF, 32'h0);
      rdc("unmapped", 8'hf9, 32'h0);
      acc(1'b1, ABS, 32'hffff_ffff);
      rdc("abs", ABS, 32'hffff_ffff);
      acc(1'b1, RES, 32'hab12_3456);
      rdc("res", RES, 32'h0012_3456);
      acc(1'b1, ZOF, 32'h5a5a_ffff);
      rdc("zoff", ZOF, 32'h0000_ffff);
      $display("test registers done");
      for (int m = 0; m < 8; m++) begin
         emulation_port_mode = m[2:0];
         cyc(1);
         `CHK("oe", {3{m == 1 || m == 2}}, {a_oe, b_oe, z_oe})
      end
      $display("test modes done");
      acc(1'b1, RES, 32'h2);
      acc(1'b1, ZOF, 32'h0);
      emulation_port_mode = 3'h1;
      fb_turns = 32'h1;
      cyc(40);
      `CHK("pos", 8, far_u.pos)
      `CHK("z", 1'b1, z_out)
      acc(1'b1, ZOF, 32'h4000);
      cyc(2);
      `CHK("z", 1'b0, z_out)
      fb_angle = 16'h4000;
      cyc(40);
      `CHK("pos", 10, far_u.pos)
      `CHK("z", 1'b1, z_out)
      motor_direction_select = 1'b1;
      cyc(40);
      `CHK("pos", -10, far_u.pos)
      emulation_direction_select = 1'b1;
      cyc(40);
      `CHK("pos", 10, far_u.pos)
      emulation_port_mode = 3'h2;
      acc(1'b1, ABS, 32'ha);
      cyc(2);
      `CHK("z", 1'b1, z_out)
      acc(1'b1, ABS, 32'hb);
      cyc(2);
      `CHK("z", 1'b0, z_out)
      $display("test emulation done");
      foreach (hw_mode[i]) begin
         do_reset();
         acc(1'b1, RES, 32'h2);
         emulation_port_mode = hw_mode[i];
         far_u.send(hw_mode[i], 7, 1'b0);
         cyc(3);
         // The A/B walk runs in the decoder's down phase, so mode 3 wraps below zero.
         `CHK("hw count", 32'h1, handwheel_count)
         `CHK("hw turns", hw_mode[i] == 3'h3 ? 32'hffff_ffff : 32'h3, handwheel_turns)
         far_u.send(hw_mode[i], 3, 1'b1);
         cyc(3);
         `CHK("hw count", hw_mode[i] == 3'h3 ? 32'h4 : 32'h0, handwheel_count)
         `CHK("hw turns", hw_mode[i] == 3'h3 ? 32'hffff_ffff : 32'h2, handwheel_turns)
      end
      $display("test handwheel done");
      final_report();
   end
   // A hang ends the run as a mismatch.
   initial begin
      #2000000;
      num_errors++;
      final_report();
   end
endmodule
bind eei_encoder_emulation eei_monitor mon_u (.mclk, .srst, .par_addr, .par_wr, .par_rd,
   .par_rdata, .par_ack, .emulation_port_mode, .a_out, .a_oe, .b_out, .z_out);
